//--- src/oc_pkg.sv
// Constants and types for the channel output-compare mode block
// Function
// - Three-bit mode field selects reference behaviour
// - Reference active high; pin level follows polarity
// - Mode 000 ignores comparison, reference held
// - Mode 001 sets reference on match
// - Mode 010 clears reference on match
// - Mode 011 toggles reference on match
// - Mode 100 forces reference inactive
// - Mode 110 first PWM mode levels
// - Mode 111 second PWM mode levels
// - PWM level moves on compare change, or at once when entered from mode 000
// - Unbuffered compare writes take effect at once
// - Buffered writes hit copy, loaded at update
// - Mode and buffer apply only when direction 00
package oc_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] MODE_REG_OFF    = 8'h00;
  localparam logic [7:0] COMPARE_REG_OFF = 8'h04;
  localparam logic [7:0] POLARITY_OFF    = 8'h08;
  localparam logic [7:0] STATUS_OFF      = 8'h0C;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int MODE_MSB     = 14;
  localparam int MODE_LSB     = 12;
  localparam int BUF_EN_BIT   = 11;
  localparam int DIR_SEL_MSB  = 9;
  localparam int DIR_SEL_LSB  = 8;
  localparam int POLARITY_BIT = 0;
  localparam int STAT_REF_BIT = 0;
  localparam int STAT_OUT_BIT = 1;
  localparam int STAT_ACT_BIT = 2;

  // ------------------------------------------------------------------
  // Reset values and codes
  // ------------------------------------------------------------------
  localparam logic [2:0]  MODE_RST     = 3'h0;
  localparam logic        BUF_EN_RST   = 1'b0;
  localparam logic [1:0]  DIR_SEL_RST  = 2'h0;
  localparam logic [1:0]  DIR_OUTPUT   = 2'h0;
  localparam logic        POLARITY_RST = 1'b0;
  localparam logic        REF_RST      = 1'b0;
  localparam logic [31:0] COMPARE_RST  = 32'h0000_0000;

  typedef enum logic [2:0] {
    MODE_FROZEN    = 3'h0,
    MODE_SET_MATCH = 3'h1,
    MODE_CLR_MATCH = 3'h2,
    MODE_TOGGLE    = 3'h3,
    MODE_FORCE_LO  = 3'h4,
    MODE_FORCE_HI  = 3'h5,
    MODE_PWM_ONE   = 3'h6,
    MODE_PWM_TWO   = 3'h7
  } compare_mode_e;

endpackage

//--- src/oc_cmp_if.sv
// Carrier between the register side and the reference generator
`timescale 1ns/10ps
interface oc_cmp_if #(parameter int CNT_W = 16);
  logic [2:0]       channel2_compare_mode;
  logic             is_output;
  logic [CNT_W-1:0] compare_active;
  logic [CNT_W-1:0] counter_value;
  logic             count_down;
  logic             channel2_reference;

  modport regs (
    output channel2_compare_mode,
    output is_output,
    output compare_active,
    output counter_value,
    output count_down,
    input  channel2_reference
  );

  modport core (
    input  channel2_compare_mode,
    input  is_output,
    input  compare_active,
    input  counter_value,
    input  count_down,
    output channel2_reference
  );
endinterface

//--- src/oc_ref_core.sv
// Reference signal generator for one compare channel
`timescale 1ns/10ps
module oc_ref_core
  import oc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Channel carrier
  oc_cmp_if.core    cmp
);

  logic ref_q;
  logic ref_d;
  logic pwm_lvl;
  logic pwm_prev_q;
  logic mode_frozen_q;
  logic match;
  logic below;
  logic above;

  assign match = (cmp.counter_value == cmp.compare_active);
  assign below = (cmp.counter_value < cmp.compare_active);
  assign above = (cmp.counter_value > cmp.compare_active);

  // ------------------------------------------------------------------
  // PWM level from counter direction
  // ------------------------------------------------------------------
  always_comb begin
    if (cmp.channel2_compare_mode == MODE_PWM_ONE) begin
      pwm_lvl = cmp.count_down ? !above : below;
    end else begin
      pwm_lvl = cmp.count_down ? above : !below;
    end
  end

  // ------------------------------------------------------------------
  // Next reference level
  // ------------------------------------------------------------------
  always_comb begin
    ref_d = ref_q;
    if (cmp.is_output) begin
      case (cmp.channel2_compare_mode)
        MODE_FROZEN: begin
          ref_d = ref_q;
        end
        MODE_SET_MATCH: begin
          if (match) begin
            ref_d = 1'b1;
          end
        end
        MODE_CLR_MATCH: begin
          if (match) begin
            ref_d = 1'b0;
          end
        end
        MODE_TOGGLE: begin
          if (match) begin
            ref_d = !ref_q;
          end
        end
        MODE_FORCE_LO: begin
          ref_d = 1'b0;
        end
        MODE_FORCE_HI: begin
          ref_d = 1'b1;
        end
        default: begin
          // Entering from another non-frozen mode waits for a change
          if ((pwm_lvl != pwm_prev_q) || mode_frozen_q) begin
            ref_d = pwm_lvl;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_q <= REF_RST;
    end else begin
      ref_q <= ref_d;
    end
  end

  // Previous comparison result, tracked in every mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_prev_q    <= 1'b0;
      mode_frozen_q <= 1'b1;
    end else begin
      pwm_prev_q    <= pwm_lvl;
      mode_frozen_q <= (cmp.channel2_compare_mode == MODE_FROZEN);
    end
  end

  assign cmp.channel2_reference = ref_q;

endmodule

//--- src/output_compare_channel_mode.sv
// APB-attached output-compare mode block for timer channel 2
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/10ps
module output_compare_channel_mode
  import oc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Timer counter side
  input  wire logic [CNT_W-1:0] counter_value,
  input  wire logic             count_down,
  input  wire logic             update_event,
  // Channel pins
  output logic                  channel2_reference,
  output logic                  channel2_output
);

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic [2:0]       channel2_compare_mode_q;
  logic             channel2_buffer_enable_q;
  logic [1:0]       channel2_direction_select_q;
  logic             channel2_polarity_q;
  logic [CNT_W-1:0] compare_buffer_q;
  logic [CNT_W-1:0] compare_active_q;
  logic [31:0]      prdata_q;
  logic             out_q;
  logic             is_output;
  logic             buffered;
  logic             setup;
  logic             wr_access;

  oc_cmp_if #(.CNT_W(CNT_W)) cmp ();

  oc_ref_core u_core (
    .clk    (clk),
    .arst_n (arst_n),
    .cmp    (cmp)
  );

  // Decode used only by the error response
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == MODE_REG_OFF) || (a == COMPARE_REG_OFF) ||
             (a == POLARITY_OFF) || (a == STATUS_OFF);
  endfunction

  assign is_output = (channel2_direction_select_q == DIR_OUTPUT);
  assign buffered  = is_output && channel2_buffer_enable_q;
  assign setup     = psel && !penable;
  assign wr_access = psel && penable && pwrite;

  // ------------------------------------------------------------------
  // APB handshake: zero wait states
  // ------------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata  = prdata_q;

  // Mode register; status offset is read-only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      channel2_compare_mode_q     <= MODE_RST;
      channel2_buffer_enable_q    <= BUF_EN_RST;
      channel2_direction_select_q <= DIR_SEL_RST;
    end else if (wr_access && (paddr == MODE_REG_OFF)) begin
      channel2_compare_mode_q     <= pwdata[MODE_MSB:MODE_LSB];
      channel2_buffer_enable_q    <= pwdata[BUF_EN_BIT];
      channel2_direction_select_q <= pwdata[DIR_SEL_MSB:DIR_SEL_LSB];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      channel2_polarity_q <= POLARITY_RST;
    end else if (wr_access && (paddr == POLARITY_OFF)) begin
      channel2_polarity_q <= pwdata[POLARITY_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Compare value: buffer copy and active copy
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      compare_buffer_q <= COMPARE_RST[CNT_W-1:0];
    end else if (wr_access && (paddr == COMPARE_REG_OFF)) begin
      compare_buffer_q <= pwdata[CNT_W-1:0];
    end
  end

  // PWM without buffering is software's risk outside one-pulse use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      compare_active_q <= COMPARE_RST[CNT_W-1:0];
    end else if (buffered) begin
      if (update_event) begin
        compare_active_q <= compare_buffer_q;
      end
    end else if (wr_access && (paddr == COMPARE_REG_OFF)) begin
      compare_active_q <= pwdata[CNT_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= 32'h0000_0000;
      if (paddr == MODE_REG_OFF) begin
        prdata_q[MODE_MSB:MODE_LSB]       <= channel2_compare_mode_q;
        prdata_q[BUF_EN_BIT]              <= channel2_buffer_enable_q;
        prdata_q[DIR_SEL_MSB:DIR_SEL_LSB] <= channel2_direction_select_q;
      end else if (paddr == COMPARE_REG_OFF) begin
        prdata_q[CNT_W-1:0] <= buffered ? compare_buffer_q
                                        : compare_active_q;
      end else if (paddr == POLARITY_OFF) begin
        prdata_q[POLARITY_BIT] <= channel2_polarity_q;
      end else if (paddr == STATUS_OFF) begin
        prdata_q[STAT_REF_BIT] <= cmp.channel2_reference;
        prdata_q[STAT_OUT_BIT] <= out_q;
        prdata_q[STAT_ACT_BIT] <= is_output;
      end
    end
  end

  // ------------------------------------------------------------------
  // Channel carrier and pins
  // ------------------------------------------------------------------
  assign cmp.channel2_compare_mode = channel2_compare_mode_q;
  assign cmp.is_output             = is_output;
  assign cmp.compare_active        = compare_active_q;
  assign cmp.counter_value         = counter_value;
  assign cmp.count_down            = count_down;

  // Pin level follows polarity, one cycle after the reference
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_q <= POLARITY_RST;
    end else begin
      out_q <= cmp.channel2_reference ^ channel2_polarity_q;
    end
  end

  assign channel2_reference = cmp.channel2_reference;
  assign channel2_output    = out_q;

endmodule

//--- verif/oc_channel_properties.sv
// Checker for the channel reference and output pins
`timescale 1ns/10ps
module oc_channel_properties
  import oc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic             clk,
  input wire logic             arst_n,
  // Register bus
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  // Counter side and pins
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic             count_down,
  input wire logic             update_event,
  input wire logic             channel2_reference,
  input wire logic             channel2_output
);
  logic [2:0]       mode_q;
  logic [1:0]       dir_q;
  logic             buf_q;
  logic             pol_q;
  logic [CNT_W-1:0] cmp_q;
  logic [CNT_W-1:0] shd_q;
  logic             wr;
  logic             outp;
  logic             hit;
  logic             lvl1;
  logic             lvl2;

  // ----------------------------------------------------------------
  // Setting shadow, so pin checks need no internal probes
  // ----------------------------------------------------------------
  assign wr   = psel && penable && pwrite;
  assign outp = dir_q == DIR_OUTPUT;
  assign hit  = outp && counter_value == cmp_q;
  assign lvl1 = count_down ? counter_value <= cmp_q : counter_value < cmp_q;
  assign lvl2 = count_down ? counter_value > cmp_q : counter_value >= cmp_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {mode_q, buf_q, dir_q, pol_q} <= '0;
      cmp_q <= '0;
      shd_q <= '0;
    end else begin
      if (wr && paddr == MODE_REG_OFF) begin
        mode_q <= pwdata[MODE_MSB:MODE_LSB];
        buf_q  <= pwdata[BUF_EN_BIT];
        dir_q  <= pwdata[DIR_SEL_MSB:DIR_SEL_LSB];
      end
      if (wr && paddr == POLARITY_OFF) pol_q <= pwdata[POLARITY_BIT];
      if (wr && paddr == COMPARE_REG_OFF) shd_q <= pwdata[CNT_W-1:0];
      if (wr && paddr == COMPARE_REG_OFF && !(buf_q && outp)) begin
        cmp_q <= pwdata[CNT_W-1:0];
      end else if (update_event && buf_q && outp) begin
        cmp_q <= shd_q;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_frozen_hold: assert property (
    outp && mode_q == 3'h0 |=> $stable(channel2_reference))
    else $error("Reference moved while frozen");
  a_set_match: assert property (
    hit && mode_q == 3'h1 |=> channel2_reference)
    else $error("Reference not set on match");
  a_clear_match: assert property (
    hit && mode_q == 3'h2 |=> !channel2_reference)
    else $error("Reference not cleared on match");
  a_toggle_match: assert property (
    hit && mode_q == 3'h3 |=> channel2_reference != $past(channel2_reference))
    else $error("Reference not toggled on match");
  a_forced_level: assert property (
    outp && mode_q[2:1] == 2'h2 |=> channel2_reference == $past(mode_q[0]))
    else $error("Forced level wrong");
  a_pwm_first: assert property (
    outp && mode_q == 3'h6 && lvl1 != $past(lvl1)
    |=> channel2_reference == $past(lvl1))
    else $error("First PWM level wrong");
  a_pwm_second: assert property (
    outp && mode_q == 3'h7 && lvl2 != $past(lvl2)
    |=> channel2_reference == $past(lvl2))
    else $error("Second PWM level wrong");
  a_input_hold: assert property (
    !outp |=> $stable(channel2_reference))
    else $error("Reference moved while channel is input");
  a_out_polarity: assert property (
    channel2_output == $past(channel2_reference ^ pol_q))
    else $error("Output pin not reference xor polarity");
endmodule

bind output_compare_channel_mode oc_channel_properties #(.CNT_W(CNT_W)) chk (
  .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .counter_value,
  .count_down, .update_event, .channel2_reference, .channel2_output
);

//--- verif/testbench.sv
// Self-checking bench for the channel output-compare block
`timescale 1ns/10ps
module testbench import oc_pkg::*;;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rexp;
  logic [15:0] counter_value;
  logic        count_down, update_event, channel2_reference, channel2_output;
  int          bad_count = 0, check_count = 0, b;
  int          m_mode = 0, m_buf = 0, m_dir = 0, m_pol = 0, m_act = 0;
  int          m_shd = 0, m_ref = 0, m_out = 0, lv;

  output_compare_channel_mode #(.CNT_W(16)) dut (
    .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .counter_value, .count_down, .update_event,
    .channel2_reference, .channel2_output
  );

  task automatic chk_word(string s, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_bit(string s, logic e, logic g);
    chk_word(s, {31'h0, e}, {31'h0, g});
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] rd(logic [7:0] a);
    case (a)
      MODE_REG_OFF: return m_mode << MODE_LSB | m_buf << BUF_EN_BIT
                           | m_dir << DIR_SEL_LSB;
      COMPARE_REG_OFF: return (m_buf && m_dir == 0) ? m_shd : m_act;
      POLARITY_OFF: return m_pol;
      STATUS_OFF: return (m_dir == 0) << 2 | m_out << 1 | m_ref;
      default: return 32'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Reference model, one step per edge
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (arst_n) begin
      chk_bit("reference", m_ref[0], channel2_reference);
      chk_bit("output", m_out[0], channel2_output);
      if (psel && penable) begin
        chk_bit("ready", 1'b1, pready);
        chk_bit("error", !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}),
                pslverr);
        if (!pwrite) chk_word("read", rexp, prdata);
      end
      if (psel && !penable) rexp = rd(paddr);
      lv = count_down ? counter_value > m_act : counter_value >= m_act;
      if (m_mode == 6) lv = !lv;
      m_out = m_ref ^ m_pol;
      if (m_dir == 0) begin
        case (m_mode)
          1: if (counter_value == m_act) m_ref = 1;
          2: if (counter_value == m_act) m_ref = 0;
          3: if (counter_value == m_act) m_ref ^= 1;
          4: m_ref = 0;
          5: m_ref = 1;
          6, 7: m_ref = lv;
          default: ;
        endcase
      end
      if (update_event && m_buf && m_dir == 0) m_act = m_shd;
      if (psel && penable && pwrite && paddr == MODE_REG_OFF) begin
        m_mode = pwdata[14:12];
        m_buf = pwdata[11];
        m_dir = pwdata[9:8];
      end
      if (psel && penable && pwrite && paddr == POLARITY_OFF) m_pol = pwdata[0];
      if (psel && penable && pwrite && paddr == COMPARE_REG_OFF) begin
        m_shd = pwdata[15:0];
        if (!(m_buf && m_dir == 0)) m_act = pwdata[15:0];
      end
    end
  end

  always @(posedge clk) begin
    counter_value <= 16'($urandom_range(0, 7));
    count_down <= 1'($urandom_range(0, 1));
    update_event <= $urandom_range(0, 7) == 0;
  end

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100us;
    bad_count++;
    wrap_up();
  end

  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {counter_value, count_down, update_event} = '0;
    void'($urandom(87651));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a <= 16; a += 4) apb(0, 8'(a), 0);
    apb(1, STATUS_OFF, 32'hFFFF_FFFF);
    apb(0, STATUS_OFF, 0);
    $display("Test registers done");
    for (int m = 0; m < 8; m++) begin
      b = (m > 5) ? 1 : $urandom_range(0, 1);
      apb(1, MODE_REG_OFF, b << 11);
      apb(1, COMPARE_REG_OFF, $urandom_range(0, 7));
      apb(1, MODE_REG_OFF, m << 12 | b << 11);
      repeat (4) begin
        apb(1, POLARITY_OFF, $urandom_range(0, 1));
        apb(1, COMPARE_REG_OFF, $urandom_range(0, 7));
        repeat (8) @(posedge clk);
        apb(0, COMPARE_REG_OFF, 0);
      end
      $display("Test mode %0d done", m);
    end
    for (int d = 1; d < 4; d++) begin
      apb(1, MODE_REG_OFF, 32'h0000_3800 | d << 8);
      apb(1, COMPARE_REG_OFF, $urandom_range(0, 7));
      repeat (8) @(posedge clk);
      apb(0, STATUS_OFF, 0);
    end
    $display("Test direction done");
    wrap_up();
  end
endmodule
